// >>> include/cdro_pkg.sv
// Purpose: Constants for current detection and remote output block
// Assumes: 25 MHz sys_clk, AXI4-Lite register access
// Notes:   Percent levels are whole percent of rated current
package cdro_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OC_LEVEL_OFF  = 8'h00;
	localparam logic [7:0] OC_DELAY_OFF  = 8'h04;
	localparam logic [7:0] ZC_LEVEL_OFF  = 8'h08;
	localparam logic [7:0] ZC_TIME_OFF   = 8'h0c;
	localparam logic [7:0] RET_SEL_OFF   = 8'h10;
	localparam logic [7:0] DATA_A_OFF    = 8'h14;
	localparam logic [7:0] DATA_B_OFF    = 8'h18;
	localparam logic [7:0] FUNC_SEL0_OFF = 8'h1c;
	localparam logic [7:0] FUNC_SEL1_OFF = 8'h20;
	localparam logic [7:0] FUNC_SEL2_OFF = 8'h24;
	localparam logic [7:0] STATUS_OFF    = 8'h28;
	localparam logic [7:0] CURRENT_OFF   = 8'h2c;
	// ----------------------------------------
	// Reset values and ranges
	// ----------------------------------------
	localparam logic [7:0]  OC_LEVEL_RST = 8'h96;   // 150 percent
	localparam logic [7:0]  OC_LEVEL_MAX = 8'h78;   // 120 percent
	localparam logic [7:0]  ZC_LEVEL_RST = 8'h05;   // 5 percent
	localparam logic [7:0]  ZC_LEVEL_MAX = 8'hc8;   // 200 percent
	localparam logic [6:0]  OC_DELAY_RST = 7'h00;   // 0 s, unit 0.1 s
	localparam logic [6:0]  OC_DELAY_MAX = 7'h64;   // 10 s
	localparam logic [6:0]  ZC_TIME_RST  = 7'h32;   // 0.5 s, unit 0.01 s
	localparam logic [6:0]  ZC_TIME_MAX  = 7'h64;   // 1 s
	localparam logic [11:0] DATA_MASK    = 12'hfff; // 0 to 4095
	localparam logic [7:0]  FUNC_SEL_RST = 8'h00;
	// ----------------------------------------
	// Function codes
	// ----------------------------------------
	localparam logic [7:0] FC_OC_POS  = 8'h0c;   // 12
	localparam logic [7:0] FC_OC_NEG  = 8'h70;   // 112
	localparam logic [7:0] FC_ZC_POS  = 8'h0d;   // 13
	localparam logic [7:0] FC_ZC_NEG  = 8'h71;   // 113
	localparam logic [7:0] FC_REM_POS = 8'h60;   // 96
	localparam logic [7:0] FC_REM_NEG = 8'hc4;   // 196
	localparam logic [3:0] RET_CLR    = 4'h0;
	localparam logic [3:0] RET_PWR    = 4'h1;
	localparam logic [3:0] RET_RST    = 4'ha;
	localparam logic [3:0] RET_BOTH   = 4'hb;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ      = 25000000;
	localparam int TICK_US     = 10000;     // 10 ms timer tick
	localparam int TICK_CYC    = CLK_HZ / 1000000 * TICK_US;
	localparam int HOLD_MS     = 100;
	localparam int HOLD_TICKS  = HOLD_MS * 1000 / TICK_US;
	localparam int NTERM       = 3;
endpackage

// >>> logic/current_detect_remote_output.sv
// Purpose: Over/zero current flags and remote output terminal drive
// Assumes: currentPct sampled on sys_clk; drive run and reset from same domain
// Notes:   Terminal function selection is an input map held here as registers
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps

// Overview of operation
// - Overcurrent flag after level exceeded past delay
// - Overcurrent flag held on about 100 ms
// - Overcurrent level percent, range 0-120, init 150
// - Overcurrent delay 0 to 10 s, init 0
// - Zero flag after current below level past time
// - Zero flag held on 100 ms
// - Zero level percent 0-200, init 5
// - Zero time 0 to 1 s, init 0.5
// - Zero level zero disables zero detection
// - Flags respond within about 0.1 s
// - Overcurrent on terminal codes 12 or 112
// - Zero flag on terminal codes 13 or 113
// - Detection stays active during auto tuning
// - Remote signal on terminal codes 96 or 196
// - Two remote data words, 0-4095, init zero
// - Data bit one turns terminal on, sink inverted
// - Select 0 or 10: power loss clears data
// - Select 1 or 11: data kept over power loss
// - Select 10 or 11: drive reset keeps data
// - Unassigned terminal ignores its data bit
// - Remote parameters writable in any mode
// - Unused data bits read back zero
module current_detect_remote_output
	import cdro_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              powerUp,
	input  wire logic [11:0]       nvDataA,
	input  wire logic [11:0]       nvDataB,
	input  wire logic              driveReset,
	input  wire logic              driveRunning,
	input  wire logic              autoTuning,
	input  wire logic [7:0]        currentPct,
	input  wire logic [NTERM-1:0]  otherFunc,
	output logic      [NTERM-1:0]  terminalOut,
	output logic                   overcurrentFlag,
	output logic                   zeroCurrentFlag,
	output logic      [11:0]       nvSaveDataA,
	output logic      [11:0]       nvSaveDataB,
	output logic                   nvSaveEnable,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]  overcurrentLevel_reg;
	logic [6:0]  overcurrentDelay_reg;
	logic [7:0]  zeroCurrentLevel_reg;
	logic [6:0]  zeroCurrentTime_reg;
	logic [3:0]  remoteRetentionSelect_reg;
	logic [11:0] remoteDataWordA_reg;
	logic [11:0] remoteDataWordB_reg;
	logic [7:0]  terminalFunctionSelect_reg [NTERM];
	logic [7:0]  awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0]  wStrb_reg;
	logic        awHave_reg;
	logic        wHave_reg;
	logic        writeGo;
	logic        readGo;
	logic [31:0] readData;

	function automatic logic [7:0] clampPct(input logic [7:0] v, input logic [7:0] mx);
		clampPct = (v > mx) ? mx : v;
	endfunction

	function automatic logic [6:0] clampTime(input logic [31:0] v, input logic [6:0] mx);
		clampTime = (v[30:0] > {24'h0, mx}) ? mx : v[6:0];
	endfunction

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
	assign s_axi_wready  = !wHave_reg && !s_axi_bvalid;
	assign s_axi_bresp   = 2'h0;
	assign writeGo       = awHave_reg && wHave_reg && !s_axi_bvalid;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			awHave_reg <= 1'b0;
			awAddr_reg <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHave_reg <= 1'b1;
			awAddr_reg <= s_axi_awaddr;
		end else if (writeGo) begin
			awHave_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wHave_reg <= 1'b0;
			wData_reg <= 32'h0;
			wStrb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHave_reg <= 1'b1;
			wData_reg <= s_axi_wdata;
			wStrb_reg <= s_axi_wstrb;
		end else if (writeGo) begin
			wHave_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
		end else if (writeGo) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Settings ignore partial strobes without byte 0; unmapped writes are dropped with OKAY
	// Level resets to 150 percent, above its writable range; writes clamp to 120
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			overcurrentLevel_reg      <= OC_LEVEL_RST;
			overcurrentDelay_reg      <= OC_DELAY_RST;
			zeroCurrentLevel_reg      <= ZC_LEVEL_RST;
			zeroCurrentTime_reg       <= ZC_TIME_RST;
			remoteRetentionSelect_reg <= RET_CLR;
			for (int i = 0; i < NTERM; i++) begin
				terminalFunctionSelect_reg[i] <= FUNC_SEL_RST;
			end
		end else if (writeGo && wStrb_reg[0]) begin
			case (awAddr_reg)
				OC_LEVEL_OFF: overcurrentLevel_reg <= clampPct(wData_reg[7:0], OC_LEVEL_MAX);
				OC_DELAY_OFF: overcurrentDelay_reg <= clampTime(wData_reg, OC_DELAY_MAX);
				ZC_LEVEL_OFF: zeroCurrentLevel_reg <= clampPct(wData_reg[7:0], ZC_LEVEL_MAX);
				ZC_TIME_OFF:  zeroCurrentTime_reg  <= clampTime(wData_reg, ZC_TIME_MAX);
				RET_SEL_OFF: begin
					if (wData_reg[3:0] == RET_CLR || wData_reg[3:0] == RET_PWR ||
					    wData_reg[3:0] == RET_RST || wData_reg[3:0] == RET_BOTH) begin
						remoteRetentionSelect_reg <= wData_reg[3:0];
					end
				end
				FUNC_SEL0_OFF: terminalFunctionSelect_reg[0] <= wData_reg[7:0];
				FUNC_SEL1_OFF: terminalFunctionSelect_reg[1] <= wData_reg[7:0];
				FUNC_SEL2_OFF: terminalFunctionSelect_reg[2] <= wData_reg[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Remote data words
	// ----------------------------------------
	logic keepOnDriveReset;
	logic keepOnPower;
	assign keepOnDriveReset = remoteRetentionSelect_reg[3];
	assign keepOnPower      = remoteRetentionSelect_reg[0];
	assign nvSaveDataA      = remoteDataWordA_reg;
	assign nvSaveDataB      = remoteDataWordB_reg;
	assign nvSaveEnable     = keepOnPower;

	// Written in any mode; no write-protect gating exists here
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			remoteDataWordA_reg <= 12'h000;
		end else if (powerUp) begin
			remoteDataWordA_reg <= keepOnPower ? nvDataA : 12'h000;
		end else if (driveReset && !keepOnDriveReset) begin
			remoteDataWordA_reg <= 12'h000;
		end else if (writeGo && awAddr_reg == DATA_A_OFF) begin
			if (wStrb_reg[0]) remoteDataWordA_reg[7:0]  <= wData_reg[7:0];
			if (wStrb_reg[1]) remoteDataWordA_reg[11:8] <= wData_reg[11:8];
		end
	end

	// Word B is stored and read back but drives none of the three terminals
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			remoteDataWordB_reg <= 12'h000;
		end else if (powerUp) begin
			remoteDataWordB_reg <= keepOnPower ? nvDataB : 12'h000;
		end else if (driveReset && !keepOnDriveReset) begin
			remoteDataWordB_reg <= 12'h000;
		end else if (writeGo && awAddr_reg == DATA_B_OFF) begin
			if (wStrb_reg[0]) remoteDataWordB_reg[7:0]  <= wData_reg[7:0];
			if (wStrb_reg[1]) remoteDataWordB_reg[11:8] <= wData_reg[11:8];
		end
	end

	// ----------------------------------------
	// Detection timers
	// ----------------------------------------
	logic [17:0] tickCnt_reg;
	logic        tick;
	logic [9:0]  ocCnt_reg;
	logic [9:0]  zcCnt_reg;
	logic [4:0]  ocHold_reg;
	logic [4:0]  zcHold_reg;
	logic        active;
	logic        ocCond;
	logic        zcCond;

	assign tick   = (tickCnt_reg == 18'(TICK_CYC - 1));
	assign active = driveRunning || autoTuning;
	assign ocCond = active && (currentPct > overcurrentLevel_reg);
	assign zcCond = active && (zeroCurrentLevel_reg != 8'h00) && (currentPct < zeroCurrentLevel_reg);

	always_ff @(posedge sys_clk) begin
		if (rst || tick) begin
			tickCnt_reg <= 18'h0;
		end else begin
			tickCnt_reg <= tickCnt_reg + 18'h1;
		end
	end

	// Delay units 0.1 s count as 10 ticks; resolution is one 10 ms tick, within the 0.1 s response
	always_ff @(posedge sys_clk) begin
		if (rst || !ocCond) begin
			ocCnt_reg <= 10'h0;
		end else if (tick && ocCnt_reg <= {3'h0, overcurrentDelay_reg} * 10'd10) begin
			ocCnt_reg <= ocCnt_reg + 10'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || !zcCond) begin
			zcCnt_reg <= 10'h0;
		end else if (tick && zcCnt_reg <= {3'h0, zeroCurrentTime_reg}) begin
			zcCnt_reg <= zcCnt_reg + 10'h1;
		end
	end

	logic ocTrip;
	logic zcTrip;
	// A zero delay trips at once instead of waiting out the phase of the free tick
	assign ocTrip = ocCond && (overcurrentDelay_reg == 7'h00 || ocCnt_reg > {3'h0, overcurrentDelay_reg} * 10'd10);
	assign zcTrip = zcCond && (zeroCurrentTime_reg == 7'h00 || zcCnt_reg > {3'h0, zeroCurrentTime_reg});

	// Hold counters stretch each flag; a trip still present keeps its hold reloaded
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ocHold_reg <= 5'h0;
		end else if (ocTrip) begin
			ocHold_reg <= 5'(HOLD_TICKS);
		end else if (tick && ocHold_reg != 5'h0) begin
			ocHold_reg <= ocHold_reg - 5'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			zcHold_reg <= 5'h0;
		end else if (zcTrip) begin
			zcHold_reg <= 5'(HOLD_TICKS);
		end else if (tick && zcHold_reg != 5'h0) begin
			zcHold_reg <= zcHold_reg - 5'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			overcurrentFlag <= 1'b0;
		end else begin
			overcurrentFlag <= ocTrip || ocHold_reg != 5'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			zeroCurrentFlag <= 1'b0;
		end else begin
			zeroCurrentFlag <= zcTrip || zcHold_reg != 5'h0;
		end
	end

	// ----------------------------------------
	// Terminal drive
	// ----------------------------------------
	genvar t;
	generate
		for (t = 0; t < NTERM; t++) begin : gTerm
			logic [7:0] fc;
			assign fc = terminalFunctionSelect_reg[t];
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					terminalOut[t] <= 1'b0;
				end else if (fc == FC_OC_POS) begin
					terminalOut[t] <= overcurrentFlag;
				end else if (fc == FC_OC_NEG) begin
					terminalOut[t] <= !overcurrentFlag;
				end else if (fc == FC_ZC_POS) begin
					terminalOut[t] <= zeroCurrentFlag;
				end else if (fc == FC_ZC_NEG) begin
					terminalOut[t] <= !zeroCurrentFlag;
				end else if (fc == FC_REM_POS) begin
					terminalOut[t] <= remoteDataWordA_reg[t];
				end else if (fc == FC_REM_NEG) begin
					terminalOut[t] <= !remoteDataWordA_reg[t];
				end else begin
					terminalOut[t] <= otherFunc[t];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	// arready drops while an answer waits, so one read at most is in flight
	assign s_axi_arready = !s_axi_rvalid;
	assign readGo        = s_axi_arvalid && s_axi_arready;
	assign s_axi_rresp   = 2'h0;

	always_comb begin
		case (s_axi_araddr)
			OC_LEVEL_OFF:  readData = {24'h0, overcurrentLevel_reg};
			OC_DELAY_OFF:  readData = {25'h0, overcurrentDelay_reg};
			ZC_LEVEL_OFF:  readData = {24'h0, zeroCurrentLevel_reg};
			ZC_TIME_OFF:   readData = {25'h0, zeroCurrentTime_reg};
			RET_SEL_OFF:   readData = {28'h0, remoteRetentionSelect_reg};
			DATA_A_OFF:    readData = {20'h0, remoteDataWordA_reg & DATA_MASK};
			DATA_B_OFF:    readData = {20'h0, remoteDataWordB_reg & DATA_MASK};
			FUNC_SEL0_OFF: readData = {24'h0, terminalFunctionSelect_reg[0]};
			FUNC_SEL1_OFF: readData = {24'h0, terminalFunctionSelect_reg[1]};
			FUNC_SEL2_OFF: readData = {24'h0, terminalFunctionSelect_reg[2]};
			STATUS_OFF:    readData = {29'h0, active, zeroCurrentFlag, overcurrentFlag};
			CURRENT_OFF:   readData = {24'h0, currentPct};
			default:       readData = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
		end else if (readGo) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Data is captured with the request and stands until taken
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_rdata <= 32'h0;
		end else if (readGo) begin
			s_axi_rdata <= readData;
		end
	end
endmodule

// >>> dv/cdro_asserts.sv
// Purpose: Port checks for the current detection block
// Assumes: One clock, synchronous active-high reset
// Notes:   Hold checks bound only the lower side
`timescale 1ns/10ps
module cdro_asserts
	import cdro_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        driveRunning,
	input wire logic        autoTuning,
	input wire logic [7:0]  currentPct,
	input wire logic        overcurrentFlag,
	input wire logic        zeroCurrentFlag,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	// Tick phase runs free, so one tick of slack
	localparam int HOLD_MIN = (HOLD_TICKS - 1) * TICK_CYC;
	logic [31:0] ocOnCnt;
	logic [31:0] zcOnCnt;
	logic        active;
	assign active = driveRunning || autoTuning;
	always_ff @(posedge sys_clk) begin
		if (rst || !overcurrentFlag) ocOnCnt <= '0;
		else ocOnCnt <= ocOnCnt + 32'h1;
	end
	always_ff @(posedge sys_clk) begin
		if (rst || !zeroCurrentFlag) zcOnCnt <= '0;
		else zcOnCnt <= zcOnCnt + 32'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_oc_hold;
		$fell(overcurrentFlag) |-> ocOnCnt >= HOLD_MIN;
	endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag short");
	property p_zc_hold;
		$fell(zeroCurrentFlag) |-> zcOnCnt >= HOLD_MIN;
	endproperty
	a_zc_hold: assert property (p_zc_hold) else $error("zero flag short");
	property p_oc_run;
		$rose(overcurrentFlag) |-> $past(active) || $past(active, 2) || $past(active, 3);
	endproperty
	a_oc_run: assert property (p_oc_run) else $error("overcurrent while idle");
	property p_zc_run;
		$rose(zeroCurrentFlag) |-> $past(active) || $past(active, 2) || $past(active, 3);
	endproperty
	a_zc_run: assert property (p_zc_run) else $error("zero flag while idle");
	property p_oc_cur;
		$rose(overcurrentFlag) |-> $past(currentPct) != 8'h00 || $past(currentPct, 2) != 8'h00;
	endproperty
	a_oc_cur: assert property (p_oc_cur) else $error("overcurrent at zero");
	property p_zc_cur;
		$rose(zeroCurrentFlag) |-> $past(currentPct) < 8'hc8 || $past(currentPct, 2) < 8'hc8;
	endproperty
	a_zc_cur: assert property (p_zc_cur) else $error("zero flag at high current");
	property p_b_ok;
		s_axi_bvalid |-> s_axi_bresp == 2'h0;
	endproperty
	a_b_ok: assert property (p_b_ok) else $error("write refused");
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read answered twice");
endmodule

bind current_detect_remote_output cdro_asserts i_cdro_asserts (.sys_clk, .rst, .driveRunning, .autoTuning,
	.currentPct, .overcurrentFlag, .zeroCurrentFlag, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rready);

// >>> dv/nv_store_model.sv
// Purpose: Nonvolatile store beside the block
// Assumes: Saving enabled means power-off store is armed
// Notes:   Tracks the words each cycle while saving is enabled; last value stands at power-off
`timescale 1ns/10ps
module nv_store_model (
	input  wire logic        sys_clk,
	input  wire logic        nvSaveEnable,
	input  wire logic [11:0] nvSaveDataA,
	input  wire logic [11:0] nvSaveDataB,
	output logic      [11:0] nvDataA,
	output logic      [11:0] nvDataB
);
	initial begin
		nvDataA = 12'h000;
		nvDataB = 12'h000;
	end
	always @(posedge sys_clk) begin
		if (nvSaveEnable) begin
			nvDataA <= nvSaveDataA;
			nvDataB <= nvSaveDataB;
		end
	end
endmodule

// >>> dv/tb.sv
// Purpose: Self-checking bench for current detection and remote output
// Assumes: 10 ms tick is fixed, so long holds are sampled early only
// Notes:   bready, rready and wstrb stay high
`timescale 1ns/10ps
module tb
	import cdro_pkg::*;
;
	logic        sys_clk, rst, powerUp, driveReset, driveRunning, autoTuning, nvSaveEnable;
	logic        overcurrentFlag, zeroCurrentFlag;
	logic [11:0] nvDataA, nvDataB, nvSaveDataA, nvSaveDataB;
	logic [7:0]  currentPct, s_axi_awaddr, s_axi_araddr;
	logic [2:0]  otherFunc, terminalOut;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          numErrors, checkCount, cycles;
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	current_detect_remote_output i_current_detect_remote_output (.sys_clk, .rst, .powerUp, .nvDataA, .nvDataB,
		.driveReset, .driveRunning, .autoTuning, .currentPct, .otherFunc, .terminalOut, .overcurrentFlag,
		.zeroCurrentFlag, .nvSaveDataA, .nvSaveDataB, .nvSaveEnable, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	nv_store_model i_nv_store_model (.sys_clk, .nvSaveEnable, .nvSaveDataA, .nvSaveDataB, .nvDataA, .nvDataB);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d, errors %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		check(s_axi_rdata, exp);
		check({30'h0, s_axi_rresp}, 32'h0);
	endtask
	task automatic wait_flag(input bit zc);
		int n;
		n = 0;
		while ((zc ? zeroCurrentFlag : overcurrentFlag) !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		cyc(6);
		rst <= 1'b0;
		cyc(1);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_defaults_and_clamp();
		rc(OC_LEVEL_OFF, 32'h96);
		rc(OC_DELAY_OFF, 32'h00);
		rc(ZC_LEVEL_OFF, 32'h05);
		rc(ZC_TIME_OFF, 32'h32);
		rc(DATA_A_OFF, 32'h000);
		rc(DATA_B_OFF, 32'h000);
		wr(OC_LEVEL_OFF, 32'hc8);
		rc(OC_LEVEL_OFF, 32'h78);
		wr(OC_DELAY_OFF, 32'h7f);
		rc(OC_DELAY_OFF, 32'h64);
		wr(ZC_LEVEL_OFF, 32'hff);
		rc(ZC_LEVEL_OFF, 32'hc8);
		wr(ZC_TIME_OFF, 32'h7f);
		rc(ZC_TIME_OFF, 32'h64);
		wr(DATA_A_OFF, 32'hffff_ffff);
		rc(DATA_A_OFF, 32'hfff);
		wr(DATA_B_OFF, 32'h1234_5abc);
		rc(DATA_B_OFF, 32'habc);
		wr(8'h3c, 32'h1);
		rc(8'h3c, 32'h0);
	endtask
	task automatic t_remote();
		driveRunning <= 1'b1;
		otherFunc <= 3'b100;
		wr(FUNC_SEL0_OFF, 32'h60);
		wr(FUNC_SEL1_OFF, 32'hc4);
		wr(FUNC_SEL2_OFF, 32'h00);
		wr(DATA_A_OFF, 32'h7);
		cyc(3);
		check(32'(terminalOut), 32'h5);
		otherFunc <= 3'b000;
		wr(DATA_A_OFF, 32'h0);
		cyc(3);
		check(32'(terminalOut), 32'h2);
	endtask
	task automatic t_overcurrent();
		driveRunning <= 1'b0;
		wr(OC_LEVEL_OFF, 32'h64);
		wr(OC_DELAY_OFF, 32'h00);
		wr(FUNC_SEL0_OFF, 32'h0c);
		wr(FUNC_SEL1_OFF, 32'h70);
		currentPct <= 8'h6e;
		cyc(20);
		check(32'(overcurrentFlag), 32'h0);
		driveRunning <= 1'b1;
		currentPct <= 8'h64;
		cyc(20);
		check(32'(overcurrentFlag), 32'h0);
		currentPct <= 8'h6e;
		wait_flag(1'b0);
		check(32'(overcurrentFlag), 32'h1);
		cyc(2);
		check(32'(terminalOut[1:0]), 32'h1);
		rc(STATUS_OFF, 32'h5);
		rc(CURRENT_OFF, 32'h6e);
		currentPct <= 8'h32;
		cyc(2000);
		check(32'(overcurrentFlag), 32'h1);
		driveRunning <= 1'b0;
		do_reset();
	endtask
	task automatic t_zero_current();
		autoTuning <= 1'b1;
		currentPct <= 8'h00;
		wr(ZC_LEVEL_OFF, 32'h00);
		wr(ZC_TIME_OFF, 32'h00);
		wr(FUNC_SEL0_OFF, 32'h0d);
		wr(FUNC_SEL1_OFF, 32'h71);
		cyc(50);
		check(32'(zeroCurrentFlag), 32'h0);
		wr(ZC_LEVEL_OFF, 32'h0a);
		wait_flag(1'b1);
		check(32'(zeroCurrentFlag), 32'h1);
		cyc(2);
		check(32'(terminalOut[1:0]), 32'h1);
		rc(STATUS_OFF, 32'h6);
		autoTuning <= 1'b0;
		do_reset();
	endtask
	task automatic t_retention();
		logic [3:0] sels [4];
		sels = '{4'h0, 4'h1, 4'ha, 4'hb};
		wr(FUNC_SEL0_OFF, 32'h60);
		foreach (sels[i]) begin
			wr(RET_SEL_OFF, 32'(sels[i]));
			wr(DATA_A_OFF, 32'h5);
			wr(DATA_B_OFF, 32'ha);
			driveReset <= 1'b1;
			cyc(1);
			driveReset <= 1'b0;
			cyc(1);
			rc(DATA_A_OFF, sels[i][3] ? 32'h5 : 32'h0);
			rc(DATA_B_OFF, sels[i][3] ? 32'ha : 32'h0);
			wr(DATA_A_OFF, 32'h5);
			check(32'(nvSaveEnable), 32'(sels[i][0]));
			powerUp <= 1'b1;
			cyc(1);
			powerUp <= 1'b0;
			cyc(3);
			rc(DATA_A_OFF, sels[i][0] ? 32'h5 : 32'h0);
			rc(DATA_B_OFF, (sels[i] == 4'hb) ? 32'ha : 32'h0);
			check(32'(terminalOut[0]), 32'(sels[i][0]));
		end
	endtask
	// ----------------------------------------
	// Main sequence and timeout
	// ----------------------------------------
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			final_report();
		end
	end
	initial begin
		{rst, powerUp, driveReset, driveRunning, autoTuning} = 5'b10000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'b00011;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, currentPct, otherFunc} = '0;
		s_axi_wstrb = 4'hf;
		cyc(6);
		rst <= 1'b0;
		cyc(1);
		t_defaults_and_clamp();
		t_remote();
		t_overcurrent();
		t_zero_current();
		t_retention();
		final_report();
	end
endmodule
